// File: hw/bpf_formatter.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
// Overview of operation
// [R1] Line code each track RNRZ-L or bi-phase-L
// [R2] Stagger track streams by 24/track_count bit times
// [R3] Per-bus track count, at most four
// [R4] Every track frame opens with sync word
// [R5] Same fixed frame length on every track
// [R6] Words shifted out msb first
// [R7] Optional check word ends every track frame
// [R8] Time words spread one per track slot
// [R9] Data words dealt round-robin across tracks
// [R10] Without frame time, data follows sync
// [R11] Frame time words can be switched on/off
// [R12] Passive capture of both bus channels
// [R13] Only word-structure faults count as errors
// [R14] Output word: bus, content, information fields
// [R15] Sync and parity removed before formatting
// [R16] Bus bit 4 lands at output bit 9
// [R17] Error word carries channel error label
// [R18] Four-bit content label in bits 5-8
// [R19] Bus label is bus number minus one
// [R20] Channel A/B command status data error labels
// [R21] Time, user, fill, overflow label codes
// [R22] Buffer captured words before output
// [R23] Sync pattern is FAF320
// [R24] Frame length held between 128 and 512
// [R25] Fill words carry AAAA
// [R26] Check sequence uses x16+x15+x2+1
// [R27] One common bit clock for all tracks
module bpf_formatter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bpf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Words from the passive bus receiver, sync and parity already stripped
  input wire logic mon_valid,
  input wire logic mon_chan_b,
  input wire logic [1:0] mon_kind,
  input wire logic [15:0] mon_bits,
  input wire logic [4:0] mon_err,
  // Frame time
  input wire logic [15:0] time_high,
  input wire logic [15:0] time_low,
  input wire logic [15:0] time_micro,
  // Tape track streams and their common bit clock
  output logic track_one_stream,
  output logic track_two_stream,
  output logic track_three_stream,
  output logic track_four_stream,
  output logic bit_clk_out
);
  import bpf_pkg::*;

  typedef struct packed {
    logic en;
    logic [1:0] tcm1;
    logic time_en;
    logic crc_en;
    logic par_mode;
    logic biphase;
    logic [3:0] bus_m1;
    logic [8:0] flen;
    logic [15:0] div;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run;
    logic [15:0] dcnt;
    logic phase;
    logic bclk;
    logic [4:0] bcnt;
    logic [8:0] widx;
    logic [FIFO_DEPTH-1:0][23:0] mem;
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [FIFO_AW:0] cnt;
    logic ovf;
    logic [15:0] ovf_events;
    logic [15:0] t_hi;
    logic [15:0] t_lo;
    logic [15:0] t_us;
  } bpf_state_s;

  bpf_state_s q;
  bpf_state_s next_q;

  logic half_en;
  logic bit_en;
  logic [4:0] nb;
  logic [8:0] ni;
  logic [MAX_TRACKS-1:0] ld;
  logic [MAX_TRACKS-1:0] ld_sync;
  logic [MAX_TRACKS-1:0] ld_crc;
  logic [MAX_TRACKS-1:0][23:0] ld_word;
  logic [MAX_TRACKS-1:0] line;
  logic pop;
  logic push_data;
  logic [23:0] cap_word;
  logic [7:0] crc_label;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Assemble a formatted word with either odd parity or a four-bit bus label.
  function automatic logic [23:0] fmt(input logic par, input logic [3:0] bus,
                                      input logic [3:0] cl, input logic [15:0] info);
    logic [23:0] w;
    w = {par ? {1'b0, bus[2:0]} : bus, cl, info}; // [R14] [R18] [R19]
    if (par) begin
      w[WORD_W-1] = ~^w[WORD_W-2:0];
    end
    return w;
  endfunction : fmt

  // Bit position within a word period at which a track loads its next word.
  function automatic logic [4:0] track_ofs(input logic [1:0] tcm1, input int k);
    return 5'((WORD_W / (int'(tcm1) + 1)) * k); // [R2]
  endfunction : track_ofs

  // ----------------------------------------
  // Shared bit timing
  // ----------------------------------------
  // One divider gives the half-bit pulse; every track uses the same pulses.
  assign half_en = q.run && (q.dcnt == '0); // [R27]
  assign bit_en = half_en && q.phase;
  assign nb = (q.bcnt == BIT_LAST) ? '0 : q.bcnt + 5'h01;
  assign ni = (q.bcnt != BIT_LAST) ? q.widx :
              (q.widx == q.flen - 9'h001) ? '0 : q.widx + 9'h001; // [R5]

  // ----------------------------------------
  // Capture formatting
  // ----------------------------------------
  // Label the captured word and map its sixteen bits straight into bits 9-24.
  always_comb begin
    logic [3:0] cl;
    cl = CL_DATA_A;
    if (|mon_err) begin
      cl = mon_chan_b ? CL_ERR_B : CL_ERR_A; // [R13] [R17]
    end else begin
      case (mon_kind)
        KIND_CMD: cl = mon_chan_b ? CL_CMD_B : CL_CMD_A; // [R20]
        KIND_STAT: cl = mon_chan_b ? CL_STAT_B : CL_STAT_A; // [R20]
        default: cl = mon_chan_b ? CL_DATA_B : CL_DATA_A; // [R20]
      endcase
    end
    cap_word = fmt(q.par_mode, q.bus_m1, cl, mon_bits); // [R15] [R16]
  end

  assign crc_label = {q.par_mode ? {1'b0, q.bus_m1[2:0]} : q.bus_m1, CL_CRC};

  // ----------------------------------------
  // Track word selection
  // ----------------------------------------
  // Offsets are distinct, so at most one track loads at a bit end and
  // loads follow track order, which deals data words round-robin.
  always_comb begin
    int s;
    s = 0;
    ld = '0;
    ld_sync = '0;
    ld_crc = '0;
    ld_word = '0;
    pop = 1'b0;
    for (int k = 0; k < MAX_TRACKS; k++) begin
      s = (int'(ni) - 1) * (int'(q.tcm1) + 1) + k;
      if (bit_en && (k <= int'(q.tcm1)) && (nb == track_ofs(q.tcm1, k))) begin // [R3]
        ld[k] = 1'b1;
        if (ni == '0) begin
          ld_sync[k] = 1'b1;
          ld_word[k] = SYNC_PATTERN; // [R4] [R23]
        end else if (q.time_en && (s < 3)) begin // [R8] [R10] [R11]
          case (s)
            0: ld_word[k] = fmt(q.par_mode, q.bus_m1, CL_TIME_HI, q.t_hi); // [R21]
            1: ld_word[k] = fmt(q.par_mode, q.bus_m1, CL_TIME_LO, q.t_lo); // [R21]
            default: ld_word[k] = fmt(q.par_mode, q.bus_m1, CL_TIME_US, q.t_us); // [R21]
          endcase
        end else if (q.crc_en && (ni == q.flen - 9'h001)) begin
          ld_crc[k] = 1'b1; // [R7]
        end else if (q.cnt != '0) begin
          pop = 1'b1; // [R9]
          ld_word[k] = q.mem[q.rp];
        end else begin
          ld_word[k] = fmt(q.par_mode, q.bus_m1, CL_FILL, FILL_INFO); // [R25]
        end
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic push;
    logic [23:0] pw;
    push = 1'b0;
    pw = '0;
    push_data = 1'b0;
    next_q = q;
    // APB setup cycle prepares the answer; the access cycle completes it.
    next_q.pready = psel && !penable;
    next_q.pslverr = 1'b0;
    next_q.prdata = '0;
    if (psel && !penable) begin
      case (paddr)
        CTRL_OFS: next_q.prdata = {20'h00000, q.bus_m1, 1'b0, q.biphase, q.par_mode,
                                   q.crc_en, q.time_en, q.tcm1, q.en};
        FLEN_OFS: next_q.prdata = {23'h000000, q.flen};
        DIV_OFS: next_q.prdata = {16'h0000, q.div};
        STATUS_OFS: next_q.prdata = {q.ovf_events, 6'h00,
                                     !q.biphase && (q.div >= RNRZ_DIV_LIMIT), q.ovf,
                                     3'h0, q.cnt};
        default: next_q.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && q.pready) begin
      case (paddr)
        CTRL_OFS: begin
          next_q.en = pwdata[CTRL_EN];
          next_q.tcm1 = pwdata[CTRL_TK_LO +: 2]; // [R3]
          next_q.time_en = pwdata[CTRL_TIME]; // [R11]
          next_q.crc_en = pwdata[CTRL_CRC];
          next_q.par_mode = pwdata[CTRL_PAR];
          next_q.biphase = pwdata[CTRL_BIPH]; // [R1]
          next_q.bus_m1 = pwdata[CTRL_BUS_LO +: 4];
        end
        FLEN_OFS: begin
          if (pwdata[31:9] != '0 || pwdata[8:0] > FRAME_LEN_MAX) begin
            next_q.flen = FRAME_LEN_MAX; // [R24]
          end else if (pwdata[8:0] < FRAME_LEN_MIN) begin
            next_q.flen = FRAME_LEN_MIN; // [R24]
          end else begin
            next_q.flen = pwdata[8:0];
          end
        end
        DIV_OFS: next_q.div = pwdata[15:0];
        default: next_q.en = q.en;
      endcase
    end
    // Start aligned so that the first bit end begins word 0 on track one.
    if (!q.en) begin
      next_q.run = 1'b0;
      next_q.bclk = 1'b0;
    end else if (!q.run) begin
      next_q.run = 1'b1;
      next_q.dcnt = q.div;
      next_q.phase = 1'b0;
      next_q.bcnt = BIT_LAST;
      next_q.widx = q.flen - 9'h001;
    end else if (half_en) begin
      next_q.dcnt = q.div;
      next_q.phase = ~q.phase;
      next_q.bclk = q.phase; // [R27]
      if (q.phase) begin
        next_q.bcnt = nb;
        next_q.widx = ni;
      end
    end else begin
      next_q.dcnt = q.dcnt - 16'h0001;
    end
    // Frame time is frozen as track one starts its sync word.
    if (ld_sync[0]) begin
      next_q.t_hi = time_high;
      next_q.t_lo = time_low;
      next_q.t_us = time_micro;
    end
    // Every word seen on either channel is taken while the buffer has room and no overflow is pending; none is ever answered.
    if (mon_valid) begin // [R12]
      if (q.ovf || (q.cnt == 5'(FIFO_DEPTH))) begin
        next_q.ovf = 1'b1; // [R22]
        next_q.ovf_events = q.ovf_events + 16'h0001;
      end else begin
        push = 1'b1;
        push_data = 1'b1;
        pw = cap_word;
      end
    end else if (q.ovf && (q.cnt != 5'(FIFO_DEPTH))) begin
      push = 1'b1;
      pw = fmt(q.par_mode, q.bus_m1, CL_OVF, OVF_INFO); // [R21]
      next_q.ovf = 1'b0;
    end
    if (push) begin
      next_q.mem[q.wp] = pw;
      next_q.wp = q.wp + 4'h1;
    end
    if (pop) begin
      next_q.rp = q.rp + 4'h1;
    end
    next_q.cnt = q.cnt + (push ? 5'h01 : 5'h00) - (pop ? 5'h01 : 5'h00);
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.flen <= FRAME_LEN_RESET;
      q.div <= DIV_RESET;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // Track serializers
  // ----------------------------------------
  for (genvar k = 0; k < MAX_TRACKS; k++) begin : g_trk
    bpf_track_ser u_ser (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .enable(q.run),
      .half_en(half_en),
      .first_half(!q.phase),
      .load(ld[k]),
      .load_word(ld_word[k]),
      .word_is_sync(ld_sync[k]),
      .word_is_crc(ld_crc[k]),
      .crc_label(crc_label),
      .biphase(q.biphase),
      .par_mode(q.par_mode),
      .line_out(line[k])
    );
  end

  // Outputs, all from flip-flops.
  assign track_one_stream = line[0];
  assign track_two_stream = line[1];
  assign track_three_stream = line[2];
  assign track_four_stream = line[3];
  assign bit_clk_out = q.bclk;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sync_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
    (|ld && ni == '0) |-> (ld_word[0] == SYNC_PATTERN || !ld[0]))
    else $error("frame does not open with sync");

  stagger_ofs_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R2]
    ld[1] |-> (nb == 5'(WORD_W / (int'(q.tcm1) + 1))))
    else $error("track two not offset by 24/track_count");

  track_max_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    (ld[3] |-> q.tcm1 == 2'h3) and (ld[2] |-> q.tcm1 >= 2'h2))
    else $error("load on a track beyond the count");

  fill_info_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R25]
    (ld[0] && ni > 9'h003 && !ld_crc[0] && q.cnt == '0)
      |-> (ld_word[0][INFO_W-1:0] == FILL_INFO && ld_word[0][19:16] == CL_FILL))
    else $error("fill word malformed");

  err_label_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
    (push_data && |mon_err)
      |=> (q.mem[$past(q.wp)][19:16] == ($past(mon_chan_b) ? CL_ERR_B : CL_ERR_A)))
    else $error("error word label wrong");

  bit_map_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
    push_data |=> (q.mem[$past(q.wp)][INFO_W-1:0] == $past(mon_bits)))
    else $error("bus bits not mapped to bits 9-24");

  time_slot_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R8]
    (ld[1] && q.tcm1 == 2'h3 && q.time_en && ni == 9'h001)
      |-> (ld_word[1][19:16] == CL_TIME_LO))
    else $error("track two lacks low-order time");

  flen_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R24]
    (q.flen >= FRAME_LEN_MIN) && (q.flen <= FRAME_LEN_MAX))
    else $error("frame length out of range");

  crc_slot_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
    (|ld && q.crc_en && ni == q.flen - 9'h001) |-> (ld_crc == ld))
    else $error("last word of frame is not the check word");

  four_track_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ld[3] && ld_crc[3]);
  overflow_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    q.ovf ##[1:40] !q.ovf);
  time_word_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ld[2] && q.time_en && q.tcm1 == 2'h2);
endmodule : bpf_formatter

// File: hw/bpf_pkg.sv
package bpf_pkg;
  // ----------------------------------------
  // Word and frame layout
  // ----------------------------------------
  localparam int WORD_W = 24;
  localparam int INFO_W = 16;
  localparam int MAX_TRACKS = 4;
  localparam logic [4:0] BIT_LAST = 5'(WORD_W - 1);
  localparam logic [23:0] SYNC_PATTERN = 24'hfaf320;
  localparam logic [15:0] FILL_INFO = 16'haaaa;
  localparam logic [15:0] OVF_INFO = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [8:0] FRAME_LEN_MIN = 9'h081;
  localparam logic [8:0] FRAME_LEN_MAX = 9'h1ff;
  localparam logic [8:0] FRAME_LEN_RESET = 9'h100;

  // ----------------------------------------
  // Content identification labels
  // ----------------------------------------
  localparam logic [3:0] CL_CMD_A = 4'hf;
  localparam logic [3:0] CL_STAT_A = 4'he;
  localparam logic [3:0] CL_DATA_A = 4'hd;
  localparam logic [3:0] CL_ERR_A = 4'hc;
  localparam logic [3:0] CL_CMD_B = 4'hb;
  localparam logic [3:0] CL_STAT_B = 4'ha;
  localparam logic [3:0] CL_DATA_B = 4'h9;
  localparam logic [3:0] CL_ERR_B = 4'h8;
  localparam logic [3:0] CL_TIME_HI = 4'h7;
  localparam logic [3:0] CL_TIME_LO = 4'h6;
  localparam logic [3:0] CL_TIME_US = 4'h5;
  localparam logic [3:0] CL_TIME_RSP = 4'h4;
  localparam logic [3:0] CL_USER_1 = 4'h3;
  localparam logic [3:0] CL_USER_2 = 4'h2;
  localparam logic [3:0] CL_FILL = 4'h1;
  localparam logic [3:0] CL_OVF = 4'h0;
  localparam logic [3:0] CL_CRC = CL_USER_1;

  // Monitored word kinds.
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_STAT = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;

  // ----------------------------------------
  // Register map (APB, byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] FLEN_OFS = 12'h004;
  localparam logic [11:0] DIV_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  localparam int CTRL_EN = 0;
  localparam int CTRL_TK_LO = 1;
  localparam int CTRL_TIME = 3;
  localparam int CTRL_CRC = 4;
  localparam int CTRL_PAR = 5;
  localparam int CTRL_BIPH = 6;
  localparam int CTRL_BUS_LO = 8;
  localparam int STAT_OVF = 8;
  localparam int STAT_RATE = 9;
  localparam int STAT_EVT_LO = 16;
  localparam logic [15:0] DIV_RESET = 16'h0018;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int RNRZ_MIN_BPS = 200000;
  localparam logic [15:0] RNRZ_DIV_LIMIT = 16'(CLK_HZ / (2 * RNRZ_MIN_BPS));
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
endpackage : bpf_pkg

// File: hw/bpf_track_ser.sv
`timescale 1ns/1ns
module bpf_track_ser (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Timing from the shared bit clock
  input wire logic enable,
  input wire logic half_en,
  input wire logic first_half,
  // Word load at the end of a bit
  input wire logic load,
  input wire logic [23:0] load_word,
  input wire logic word_is_sync,
  input wire logic word_is_crc,
  input wire logic [7:0] crc_label,
  // Options
  input wire logic biphase,
  input wire logic par_mode,
  // Line output
  output logic line_out
);
  import bpf_pkg::*;

  typedef struct packed {
    logic [23:0] sr;
    logic [15:0] crc;
    logic cur_crc;
    logic act;
    logic [14:0] scr;
    logic out;
  } bpf_ser_s;

  bpf_ser_s q;
  bpf_ser_s n;

  // ----------------------------------------
  // Shifting, line coding and check sequence
  // ----------------------------------------
  // Each bit has two halves; the word advances at the half pulse that begins the second half.
  always_comb begin
    logic rb;
    logic fb;
    logic [23:0] cw;
    rb = 1'b0;
    fb = 1'b0;
    cw = '0;
    n = q;
    if (!enable) begin
      n = '0;
    end else if (half_en) begin
      if (first_half) begin
        if (q.act) begin
          rb = q.sr[WORD_W-1] ^ q.scr[13] ^ q.scr[14];
          if (biphase) begin
            n.out = q.sr[WORD_W-1]; // [R1]
          end else begin
            n.out = rb; // [R1]
            n.scr = {q.scr[13:0], rb};
          end
        end
      end else begin
        if (q.act && biphase) begin
          n.out = ~q.sr[WORD_W-1]; // [R1]
        end
        // The check word itself never feeds the check sequence.
        if (q.act && !q.cur_crc) begin
          fb = q.sr[WORD_W-1] ^ q.crc[15];
          n.crc = {q.crc[14:0], 1'b0} ^ (fb ? CRC_POLY : '0); // [R26]
        end
        n.sr = {q.sr[WORD_W-2:0], 1'b0}; // [R6]
        if (load) begin
          cw = {crc_label, n.crc}; // [R7]
          if (par_mode) begin
            cw[WORD_W-1] = ~^cw[WORD_W-2:0];
          end
          n.sr = word_is_crc ? cw : load_word;
          n.cur_crc = word_is_crc;
          n.act = 1'b1;
          if (word_is_sync) begin
            n.crc = CRC_INIT; // [R26]
          end
        end
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign line_out = q.out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  biph_second_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R1]
    (enable && half_en && !first_half && q.act && biphase)
      |=> (line_out == ~$past(line_out)))
    else $error("bi-phase second half is not the inverse of the first");

  crc_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R26]
    (enable && half_en && !first_half && load && word_is_sync) |=> (q.crc == CRC_INIT))
    else $error("check sequence not restarted at frame sync");
endmodule : bpf_track_ser

// File: tb/bpf_tape_model.sv
`timescale 1ns/1ns
module bpf_tape_model (
  // Clock, line timing and mode
  input wire logic sys_clk,
  input wire logic bit_clk_out,
  input wire logic biphase,
  input wire logic clr,
  // Recorded tracks
  input wire logic [3:0] lines
);
  import bpf_pkg::*;
  logic prev_clk = 0;
  int cnt = 0;
  logic [23:0] sh[4] = '{default: 0};
  logic [15:0] scr[4] = '{default: 0};
  int bp[4] = '{default: 0};
  int wc[4] = '{default: 0};
  int nsync[4] = '{default: 0};
  int sync_at[4] = '{default: 0};
  int flen_bits[4] = '{default: 0};
  logic [15:0] crc[4] = '{default: 0};
  logic [15:0] fcs[4] = '{default: 0};

  // One msb-first step of the frame check sequence.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((b ^ c[15]) ? CRC_POLY : 16'h0000);
  endfunction : crc_step
  logic [23:0] words[4][128];

  // Decode every track once a bit, early in its second half, and frame the words.
  always @(negedge sys_clk) begin : dec
    logic d;
    for (int k = 0; k < 4; k++) begin
      // The descrambler restarts together with the transmitter.
      if (clr) begin
        nsync[k] = 0;
        scr[k] = '0;
      end
    end
    if (bit_clk_out && !prev_clk) begin
      cnt++;
      for (int k = 0; k < 4; k++) begin
        d = biphase ? ~lines[k] : lines[k] ^ scr[k][13] ^ scr[k][14];
        scr[k] = {scr[k][14:0], lines[k]};
        sh[k] = {sh[k][22:0], d};
        bp[k]++;
        if (sh[k] == SYNC_PATTERN) begin
          if (nsync[k] > 0) begin
            flen_bits[k] = cnt - sync_at[k];
          end
          sync_at[k] = cnt;
          nsync[k]++;
          bp[k] = 0;
          wc[k] = 0;
          crc[k] = CRC_INIT;
          for (int i = WORD_W - 1; i >= 0; i--) begin
            crc[k] = crc_step(crc[k], SYNC_PATTERN[i]);
          end
        end else begin
          // Word 127 after sync is the check word and stays out of the sequence.
          if (wc[k] < 127) begin
            crc[k] = crc_step(crc[k], d);
          end
          if (bp[k] == 24) begin
            if (wc[k] < 128) begin
              words[k][wc[k]] = sh[k];
            end
            if (wc[k] == 127) begin
              fcs[k] = crc[k];
            end
            wc[k]++;
            bp[k] = 0;
          end
        end
      end
    end
    prev_clk = bit_clk_out;
  end
endmodule : bpf_tape_model

// File: tb/tb_bus_monitor_pcm_track_formatter.sv
`timescale 1ns/1ns
module tb_bus_monitor_pcm_track_formatter;
  import bpf_pkg::*;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, biph = 0, err;
  logic mon_valid = 0, mon_chan_b = 0, pready, pslverr, bclk;
  logic [1:0] mon_kind = 0;
  logic [4:0] mon_err = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] mon_bits = 0, t_hi = 0, t_lo = 0, t_us = 0;
  logic [3:0] lines;
  int num_errors = 0, n_compared = 0, seed = 32'h0efaf3a8, cyc = 0;
  logic [23:0] exp_q[$];

  bpf_formatter i_bpf_formatter (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mon_valid, .mon_chan_b, .mon_kind, .mon_bits,
    .mon_err, .time_high(t_hi), .time_low(t_lo), .time_micro(t_us),
    .track_one_stream(lines[0]), .track_two_stream(lines[1]),
    .track_three_stream(lines[2]), .track_four_stream(lines[3]), .bit_clk_out(bclk));
  bpf_tape_model i_bpf_tape_model (.sys_clk, .bit_clk_out(bclk), .biphase(biph), .clr,
    .lines);

  // Clock and a hang guard.
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input string name, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask : check

  // Formatted word image: odd parity and a 3-bit label, or a 4-bit label.
  function automatic logic [23:0] fw(input logic par, input logic [3:0] bl,
    input logic [3:0] cl, input logic [15:0] info);
    return par ? {~^{bl[2:0], cl, info}, bl[2:0], cl, info} : {bl, cl, info};
  endfunction : fw

  // One APB transfer; waits on pready, then takes read data and response.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Back-to-back captured bus words; the model keeps their formatted image.
  // No word leaves the buffer during a burst, so words past its depth are lost.
  task mon_burst(input int n, input logic par, input logic [3:0] bl);
    logic c;
    logic [1:0] kd;
    logic [15:0] b;
    logic [4:0] e;
    logic [3:0] cl;
    for (int i = 0; i < n; i++) begin
      c = $random(seed);
      kd = $random(seed);
      b = $random(seed);
      e = $random(seed);
      if (e[4:3] != 2'h0) begin
        e = 5'h0;
      end
      @(posedge sys_clk);
      mon_valid <= 1;
      mon_chan_b <= c;
      mon_kind <= kd;
      mon_bits <= b;
      mon_err <= e;
      cl = c ? 4'hb : 4'hf;
      cl = cl - ((e != 5'h0) ? 4'h3 : (kd == 2'h3) ? 4'h2 : 4'(kd));
      if (i < FIFO_DEPTH) begin
        exp_q.push_back(fw(par, bl, cl, b));
      end
    end
    @(posedge sys_clk);
    mon_valid <= 0;
    if (n > FIFO_DEPTH) begin
      exp_q.push_back(fw(par, bl, CL_OVF, OVF_INFO));
    end
  endtask : mon_burst

  // One configuration run, checked over the first frame of every track.
  task run(input int tk, input logic tm, input logic bi, input logic crc, input logic par,
    input logic [3:0] bl, input int n);
    logic [23:0] e;
    logic [15:0] th, tl, tu;
    apb(1, CTRL_OFS, 32'h0);
    clr <= 1;
    biph <= bi;
    exp_q.delete();
    th = $random(seed);
    tl = $random(seed);
    tu = $random(seed);
    t_hi <= th;
    t_lo <= tl;
    t_us <= tu;
    if (tm) begin
      exp_q = '{fw(par, bl, CL_TIME_HI, th), fw(par, bl, CL_TIME_LO, tl),
        fw(par, bl, CL_TIME_US, tu)};
    end
    apb(1, CTRL_OFS, 32'({bl, 1'b0, bi, par, crc, tm, 2'(tk - 1), 1'b1}));
    clr <= 0;
    mon_burst(n, par, bl);
    while (i_bpf_tape_model.nsync[tk - 1] < 2) begin
      @(posedge sys_clk);
    end
    for (int s = 0; s < 8 * tk + exp_q.size(); s++) begin
      e = (s < exp_q.size()) ? exp_q[s] : fw(par, bl, CL_FILL, FILL_INFO);
      check("word", e, i_bpf_tape_model.words[s % tk][s / tk]);
    end
    for (int k = 0; k < 4; k++) begin
      if (k >= tk) begin
        check("unused track", 0, i_bpf_tape_model.nsync[k]);
      end else begin
        check("frame bits", 129 * 24, i_bpf_tape_model.flen_bits[k]);
        if (crc) begin
          check("crc label", CL_CRC, i_bpf_tape_model.words[k][127][19:16]);
          check("crc fcs", i_bpf_tape_model.fcs[k],
            i_bpf_tape_model.words[k][127][15:0]);
        end
        if (k > 0) begin
          check("stagger", 24 / tk, i_bpf_tape_model.sync_at[k] -
            i_bpf_tape_model.sync_at[k - 1]);
        end
      end
    end
  endtask : run

  task results;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int fv[4] = '{0, 128, 511, 129};
    repeat (10) @(posedge sys_clk);
    rst_b <= 1;
    apb(0, FLEN_OFS, 32'h0);
    check("flen reset", 32'h100, 32'(rd[8:0]));
    apb(0, DIV_OFS, 32'h0);
    check("div reset", 32'(DIV_RESET), 32'(rd[15:0]));
    apb(0, 12'h010, 32'h0);
    check("unmapped err", 1, err);
    check("unmapped data", 0, rd);
    foreach (fv[i]) begin
      apb(1, FLEN_OFS, fv[i]);
      apb(0, FLEN_OFS, 32'h0);
      check("flen clamp", (fv[i] < 129) ? 129 : fv[i], 32'(rd[8:0]));
    end
    for (int v = 49; v < 51; v++) begin
      apb(1, DIV_OFS, v);
      apb(0, STATUS_OFS, 32'h0);
      check("rate flag", v >= 50, rd[STAT_RATE]);
    end
    apb(1, DIV_OFS, 32'h0);
    run(1, 0, 1, 0, 0, 4'h4, 10);
    run(4, 1, 0, 1, 1, 4'h9, 12);
    run(2, 0, 0, 0, 0, 4'hf, 20);
    apb(0, STATUS_OFS, 32'h0);
    check("lost words", 20 - FIFO_DEPTH, rd[STAT_EVT_LO +: 16]);
    check("overflow pending", 0, rd[STAT_OVF]);
    run(3, 1, 1, 0, 0, 4'h0, 9);
    results();
  end
endmodule : tb_bus_monitor_pcm_track_formatter
